/* File: rtl/eelc_pkg.sv */
// Constants shared by the edge event line controller and its edge catcher
package eelc_pkg;
  // ==========================================================================
  // Sizes
  localparam int NUM_LINES = 19;
  localparam int NUM_EXT   = 16;
  localparam int NUM_PINS  = 112;
  localparam int SEL_W     = 7;
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;
  localparam int NUM_SEL_WORDS = 4;
  localparam int SELS_PER_WORD = 4;
  localparam int BYTE_W    = 8;

  // ==========================================================================
  // Internal line numbers
  localparam int LINE_SUPPLY = 16;
  localparam int LINE_RTC    = 17;
  localparam int LINE_AUX    = 18;

  // ==========================================================================
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_EVT_MASK = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_RISE_EN  = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_FALL_EN  = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_PEND     = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_PIN_SEL0 = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_PIN_SEL3 = 8'h2c;

  // ==========================================================================
  // Reset values and fields
  localparam logic [NUM_LINES-1:0] LINES_RST = 19'h00000;
  localparam logic [SEL_W-1:0]     SEL_RST   = 7'h00;
  localparam int                   CTRL_MON_EN_BIT = 0;
  localparam logic [DATA_W-1:0]    DATA_ZERO = 32'h00000000;
endpackage

/* File: rtl/eelc_cap_if.sv */
// Carrier between the register side and the asynchronous edge catcher
`timescale 1ns/1ps
interface eelc_cap_if;
  import eelc_pkg::*;
  logic [NUM_LINES-1:0] src;
  logic [NUM_LINES-1:0] rise_tgl;
  logic [NUM_LINES-1:0] fall_tgl;
  modport ctrl  (output src, input rise_tgl, input fall_tgl);
  modport catch (input src, output rise_tgl, output fall_tgl);
endinterface

/* File: rtl/eelc_edge_catch.sv */
// Per-line toggle flops clocked by the line itself, so short pulses are caught
`timescale 1ns/1ps
module eelc_edge_catch
  import eelc_pkg::*;
(
  input  wire logic  i_resetn,
  eelc_cap_if.catch  cap
);
  import eelc_pkg::*;

  // ==========================================================================
  // Toggle capture
  // Each edge flips a toggle; the system clock later sees the change, so a
  // pulse narrower than one clock period still leaves a mark. Two edges of
  // the same kind between clock samples merge into none - a known limit.
  for (genvar g = 0; g < NUM_LINES; g++) begin : g_line
    logic rise_r;
    logic fall_r;
    always_ff @(posedge cap.src[g] or negedge i_resetn) begin
      if (!i_resetn) begin
        rise_r <= 1'b0;
      end else begin
        rise_r <= ~rise_r;
      end
    end
    always_ff @(negedge cap.src[g] or negedge i_resetn) begin
      if (!i_resetn) begin
        fall_r <= 1'b0;
      end else begin
        fall_r <= ~fall_r;
      end
    end
    assign cap.rise_tgl[g] = rise_r;
    assign cap.fall_tgl[g] = fall_r;
  end
endmodule

/* File: rtl/eelc_top.sv */
// Edge event line controller: APB registers, line sources, sync and pending
`timescale 1ns/1ps
module eelc_top
  import eelc_pkg::*;
(
  input  wire logic                 I_CLK_SYS,
  input  wire logic                 I_RESETN,
  input  wire logic                 I_PSEL,
  input  wire logic                 I_PENABLE,
  input  wire logic                 I_PWRITE,
  input  wire logic [ADDR_W-1:0]    I_PADDR,
  input  wire logic [DATA_W-1:0]    I_PWDATA,
  input  wire logic [3:0]           I_PSTRB,
  output logic      [DATA_W-1:0]    O_PRDATA,
  output logic                      O_PREADY,
  output logic                      O_PSLVERR,
  input  wire logic [NUM_PINS-1:0]  I_GPIO,
  input  wire logic                 I_SUPPLY_BELOW,
  input  wire logic                 I_RTC_ALARM,
  input  wire logic                 I_AUX_EVT,
  output logic      [NUM_LINES-1:0] O_IRQ,
  output logic      [NUM_LINES-1:0] O_EVT,
  output logic                      O_WAKE
);
  import eelc_pkg::*;

  // ==========================================================================
  // Functions
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v,
                                              input logic [DATA_W-1:0] new_v,
                                              input logic [3:0]        strb);
    logic [DATA_W-1:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*BYTE_W +: BYTE_W] = new_v[b*BYTE_W +: BYTE_W];
      end
    end
    return res;
  endfunction

  function automatic logic pick_pin(input logic [NUM_PINS-1:0] pins,
                                    input logic [SEL_W-1:0]    sel);
    logic res;
    res = 1'b0;
    for (int p = 0; p < NUM_PINS; p++) begin
      if (sel == SEL_W'(p)) begin
        res = pins[p];
      end
    end
    return res;
  endfunction

  // ==========================================================================
  // Registers
  logic [NUM_LINES-1:0] irq_mask_r;
  logic [NUM_LINES-1:0] evt_mask_r;
  logic [NUM_LINES-1:0] rise_en_r;
  logic [NUM_LINES-1:0] fall_en_r;
  logic [NUM_LINES-1:0] pend_r;
  logic [NUM_LINES-1:0] pend_nxt;
  logic                 mon_en_r;
  logic [SEL_W-1:0]     pin_sel_r [NUM_EXT];
  logic [DATA_W-1:0]    prdata_r;
  logic [DATA_W-1:0]    rd_nxt;
  logic                 err_r;
  logic [NUM_LINES-1:0] evt_r;

  // ==========================================================================
  // Bus decode
  wire setup_rd   = I_PSEL & ~I_PENABLE;
  wire acc_wr     = I_PSEL & I_PENABLE & I_PWRITE;
  wire hit_imr    = (I_PADDR == OFF_IRQ_MASK);
  wire hit_emr    = (I_PADDR == OFF_EVT_MASK);
  wire hit_rise   = (I_PADDR == OFF_RISE_EN);
  wire hit_fall   = (I_PADDR == OFF_FALL_EN);
  wire hit_pend   = (I_PADDR == OFF_PEND);
  wire hit_ctrl   = (I_PADDR == OFF_CTRL);
  wire hit_sel    = (I_PADDR >= OFF_PIN_SEL0) && (I_PADDR <= OFF_PIN_SEL3) && (I_PADDR[1:0] == 2'b00);
  wire hit_any    = hit_imr | hit_emr | hit_rise | hit_fall | hit_pend | hit_ctrl | hit_sel;
  wire [1:0] sel_word = 2'((I_PADDR - OFF_PIN_SEL0) >> 2);
  wire [DATA_W-1:0] wmask = merge(DATA_ZERO, I_PWDATA, I_PSTRB);

  wire [DATA_W-1:0] lines32_imr  = merge({13'h0000, irq_mask_r}, I_PWDATA, I_PSTRB);
  wire [DATA_W-1:0] lines32_emr  = merge({13'h0000, evt_mask_r}, I_PWDATA, I_PSTRB);
  wire [DATA_W-1:0] lines32_rise = merge({13'h0000, rise_en_r}, I_PWDATA, I_PSTRB);
  wire [DATA_W-1:0] lines32_fall = merge({13'h0000, fall_en_r}, I_PWDATA, I_PSTRB);
  wire [DATA_W-1:0] ctrl32       = merge({31'h00000000, mon_en_r}, I_PWDATA, I_PSTRB);

  // ==========================================================================
  // Line sources
  eelc_cap_if cap_bus ();
  for (genvar e = 0; e < NUM_EXT; e++) begin : g_ext
    assign cap_bus.src[e] = pick_pin(I_GPIO, pin_sel_r[e]);
  end
  // Gating keeps the monitor silent until enabled; enabling while already
  // below the threshold shows as a rising edge.
  assign cap_bus.src[LINE_SUPPLY] = I_SUPPLY_BELOW & mon_en_r;
  assign cap_bus.src[LINE_RTC]    = I_RTC_ALARM;
  assign cap_bus.src[LINE_AUX]    = I_AUX_EVT;

  eelc_edge_catch u_catch (
    .i_resetn (I_RESETN),
    .cap      (cap_bus)
  );

  // ==========================================================================
  // Toggle synchronisers
  logic [NUM_LINES-1:0] rise_s1_r;
  logic [NUM_LINES-1:0] rise_s2_r;
  logic [NUM_LINES-1:0] rise_seen_r;
  logic [NUM_LINES-1:0] fall_s1_r;
  logic [NUM_LINES-1:0] fall_s2_r;
  logic [NUM_LINES-1:0] fall_seen_r;

  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rise_s1_r   <= LINES_RST;
      rise_s2_r   <= LINES_RST;
      rise_seen_r <= LINES_RST;
      fall_s1_r   <= LINES_RST;
      fall_s2_r   <= LINES_RST;
      fall_seen_r <= LINES_RST;
    end else begin
      rise_s1_r   <= cap_bus.rise_tgl;
      rise_s2_r   <= rise_s1_r;
      rise_seen_r <= rise_s2_r;
      fall_s1_r   <= cap_bus.fall_tgl;
      fall_s2_r   <= fall_s1_r;
      fall_seen_r <= fall_s2_r;
    end
  end

  wire [NUM_LINES-1:0] rise_evt = rise_s2_r ^ rise_seen_r;
  wire [NUM_LINES-1:0] fall_evt = fall_s2_r ^ fall_seen_r;
  wire [NUM_LINES-1:0] edge_hit = (rise_evt & rise_en_r) | (fall_evt & fall_en_r);
  wire [NUM_LINES-1:0] pend_clr = (acc_wr & hit_pend) ? wmask[NUM_LINES-1:0] : LINES_RST;

  // New edge wins over a clear in the same cycle
  assign pend_nxt = (pend_r & ~pend_clr) | edge_hit;

  // ==========================================================================
  // Control registers
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      irq_mask_r <= LINES_RST;
      evt_mask_r <= LINES_RST;
      rise_en_r  <= LINES_RST;
      fall_en_r  <= LINES_RST;
      mon_en_r   <= 1'b0;
      pend_r     <= LINES_RST;
      evt_r      <= LINES_RST;
    end else begin
      pend_r <= pend_nxt;
      evt_r  <= edge_hit & evt_mask_r;
      if (acc_wr && hit_imr) begin
        irq_mask_r <= lines32_imr[NUM_LINES-1:0];
      end
      if (acc_wr && hit_emr) begin
        evt_mask_r <= lines32_emr[NUM_LINES-1:0];
      end
      if (acc_wr && hit_rise) begin
        rise_en_r <= lines32_rise[NUM_LINES-1:0];
      end
      if (acc_wr && hit_fall) begin
        fall_en_r <= lines32_fall[NUM_LINES-1:0];
      end
      if (acc_wr && hit_ctrl) begin
        mon_en_r <= ctrl32[CTRL_MON_EN_BIT];
      end
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      for (int i = 0; i < NUM_EXT; i++) begin
        pin_sel_r[i] <= SEL_RST;
      end
    end else begin
      for (int j = 0; j < SELS_PER_WORD; j++) begin
        if (acc_wr && hit_sel && I_PSTRB[j]) begin
          pin_sel_r[int'(sel_word)*SELS_PER_WORD + j] <= I_PWDATA[j*BYTE_W +: SEL_W];
        end
      end
    end
  end

  // ==========================================================================
  // Read path
  // Data is latched in the setup cycle so the access phase needs no wait.
  always_comb begin
    rd_nxt = DATA_ZERO;
    if (hit_imr) begin
      rd_nxt[NUM_LINES-1:0] = irq_mask_r;
    end else if (hit_emr) begin
      rd_nxt[NUM_LINES-1:0] = evt_mask_r;
    end else if (hit_rise) begin
      rd_nxt[NUM_LINES-1:0] = rise_en_r;
    end else if (hit_fall) begin
      rd_nxt[NUM_LINES-1:0] = fall_en_r;
    end else if (hit_pend) begin
      rd_nxt[NUM_LINES-1:0] = pend_r;
    end else if (hit_ctrl) begin
      rd_nxt[CTRL_MON_EN_BIT] = mon_en_r;
    end else if (hit_sel) begin
      for (int k = 0; k < SELS_PER_WORD; k++) begin
        rd_nxt[k*BYTE_W +: SEL_W] = pin_sel_r[int'(sel_word)*SELS_PER_WORD + k];
      end
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      prdata_r <= DATA_ZERO;
      err_r    <= 1'b0;
    end else if (setup_rd) begin
      prdata_r <= I_PWRITE ? DATA_ZERO : rd_nxt;
      err_r    <= ~hit_any;
    end
  end

  // ==========================================================================
  // Outputs
  assign O_PRDATA  = prdata_r;
  assign O_PREADY  = 1'b1;
  assign O_PSLVERR = I_PSEL & I_PENABLE & err_r;
  assign O_IRQ     = pend_r & irq_mask_r;
  assign O_EVT     = evt_r;
  // Asynchronous path so a wake works with the system clock stopped;
  // it may glitch, so the power controller must only use it as a wake.
  assign O_WAKE = |(((cap_bus.rise_tgl ^ rise_seen_r) & rise_en_r |
                     (cap_bus.fall_tgl ^ fall_seen_r) & fall_en_r) &
                    (irq_mask_r | evt_mask_r)) | (|O_IRQ);
endmodule

/* File: test/eelc_pin_model.sv */
// Line source and request-side model of the edge event line controller
`timescale 1ns/1ps
module eelc_pin_model
(
  input  wire logic [eelc_pkg::NUM_LINES-1:0] i_evt,
  input  wire logic                           i_clk,
  output logic      [eelc_pkg::NUM_PINS-1:0]  o_gpio,
  output logic                                o_below,
  output logic                                o_alarm,
  output logic                                o_aux
);
  import eelc_pkg::*;
  logic [NUM_PINS+2:0] lv = '0;
  int                  evt_cnt [NUM_LINES];
  assign o_gpio  = lv[NUM_PINS-1:0];
  assign o_below = lv[NUM_PINS];
  assign o_alarm = lv[NUM_PINS+1];
  assign o_aux   = lv[NUM_PINS+2];
  // Pins are asynchronous; a level change lands just after a clock edge
  task automatic drv(input int k, input logic v);
    lv[k] <= v;
  endtask
  // Narrow pulse inside one clock period, so only the toggles can see it
  task automatic pulse(input int k, input int ns);
    lv[k] <= 1'b1;
    #(ns);
    lv[k] <= 1'b0;
  endtask
  // Event pulses last one cycle, so each high sample is one request
  always @(posedge i_clk) begin
    for (int i = 0; i < NUM_LINES; i++) begin
      if (i_evt[i] === 1'b1) evt_cnt[i]++;
    end
  end
endmodule

/* File: test/eelc_checker.sv */
// Port assertions of the edge event line controller
`timescale 1ns/1ps
module eelc_chk
(
  input wire logic                           I_CLK_SYS,
  input wire logic                           I_RESETN,
  input wire logic                           I_PSEL,
  input wire logic                           I_PENABLE,
  input wire logic                           I_PWRITE,
  input wire logic [eelc_pkg::ADDR_W-1:0]    I_PADDR,
  input wire logic [eelc_pkg::DATA_W-1:0]    O_PRDATA,
  input wire logic                           O_PREADY,
  input wire logic                           O_PSLVERR,
  input wire logic [eelc_pkg::NUM_LINES-1:0] O_IRQ,
  input wire logic                           O_WAKE
);
  import eelc_pkg::*;
  // ==========================================
  // Decode
  wire acc    = I_PSEL && I_PENABLE;
  wire wr_acc = acc && I_PWRITE;
  wire mapped = (I_PADDR[1:0] == 2'h0) && (I_PADDR <= 8'h2c) && (I_PADDR != 8'h10) && (I_PADDR != 8'h1c);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RESETN);
  // ==========================================
  // Assertions
  chk_ready_high: assert property (O_PREADY)
    else $error("ready low");
  chk_err_access: assert property (O_PSLVERR |-> acc)
    else $error("error outside access");
  chk_err_map: assert property (acc |-> O_PSLVERR == !mapped)
    else $error("error flag wrong");
  chk_wr_zero: assert property (wr_acc |-> O_PRDATA == DATA_ZERO)
    else $error("read data on write");
  chk_upper_zero: assert property (acc && !I_PWRITE && I_PADDR < 8'h18 |-> O_PRDATA[31:19] == 13'h0000)
    else $error("line bits above 18 set");
  chk_rdata_hold: assert property (!(I_PSEL && !I_PENABLE) |=> $stable(O_PRDATA))
    else $error("read data moved");
  chk_irq_hold: assert property (!wr_acc |=> (O_IRQ & $past(O_IRQ)) == $past(O_IRQ))
    else $error("request dropped without write");
  chk_wake_irq: assert property (|O_IRQ |-> O_WAKE)
    else $error("no wake with request");
endmodule
bind eelc_top eelc_chk i_chk (.I_CLK_SYS(I_CLK_SYS), .I_RESETN(I_RESETN), .I_PSEL(I_PSEL),
  .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .O_PRDATA(O_PRDATA),
  .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_IRQ(O_IRQ), .O_WAKE(O_WAKE));

/* File: test/tb_top.sv */
// Self-checking bench of the edge event line controller
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; $display("Error %0t: got %h exp %h", $time, a, b); end end
module tb_top;
  import eelc_pkg::*;
  logic                 clk, rstn, psel, pen, pwr, pready, pslverr, wake, below, alarm, aux;
  logic [ADDR_W-1:0]    paddr, ad;
  logic [DATA_W-1:0]    pwdata, prdata, rd, r, f, v;
  logic [NUM_PINS-1:0]  gpio;
  logic [NUM_LINES-1:0] irq, evt;
  logic [3:0]           stb;
  logic [31:0]          seed = 32'h15;
  logic [7:0]           offs [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h20, 8'h2c};
  int                   fail_count = 0, compares = 0, ln, pin, c;
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  eelc_top i_dut (.I_CLK_SYS(clk), .I_RESETN(rstn), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(stb), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_GPIO(gpio), .I_SUPPLY_BELOW(below), .I_RTC_ALARM(alarm), .I_AUX_EVT(aux),
    .O_IRQ(irq), .O_EVT(evt), .O_WAKE(wake));
  eelc_pin_model i_pm (.i_evt(evt), .i_clk(clk), .o_gpio(gpio), .o_below(below), .o_alarm(alarm),
    .o_aux(aux));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Selector bytes keep seven bits, line registers nineteen
  function automatic logic [31:0] exp_rd(input logic [7:0] a, input logic [31:0] x);
    return (a < 8'h20) ? (x & 32'h7ffff) : (x & 32'h7f7f7f7f);
  endfunction
  // One idle cycle after each transfer keeps drivers single per step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 0);
    `CHK(rd, e)
  endtask
  task automatic step(input int k, input logic lvl, input logic [18:0] e);
    apb(1, OFF_PEND, 32'h7ffff);
    i_pm.drv(k, lvl);
    repeat (6) @(posedge clk);
    rdchk(OFF_PEND, {13'h0, e});
  endtask
  task automatic summarize();
    $display("Compares %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #400000;
    fail_count++;
    summarize();
  end
  initial begin
    rstn = 0; psel = 0; pen = 0; pwr = 0; paddr = 0; pwdata = 0;
    stb = 4'hf;
    repeat (6) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    for (int a = 0; a < 48; a += 4) rdchk(a[7:0], 0);
    apb(1, 8'h10, rnd());
    rdchk(8'h10, 0);
    for (int i = 0; i < 12; i++) begin
      ad = offs[i % 6];
      v = rnd();
      apb(1, ad, v);
      rdchk(ad, exp_rd(ad, v));
    end
    $display("register test done");
    for (int m = 0; m < 3; m++) begin
      ln = rnd() % 16;
      pin = rnd() % 112;
      r = (m != 1) ? 32'h1 << ln : 0;
      f = (m != 0) ? 32'h1 << ln : 0;
      apb(1, OFF_PIN_SEL0 + 8'(4 * (ln / 4)), 32'(pin) << (8 * (ln % 4)));
      apb(1, OFF_RISE_EN, r);
      apb(1, OFF_FALL_EN, f);
      apb(1, OFF_IRQ_MASK, 32'h1 << ln);
      apb(1, OFF_EVT_MASK, 32'h1 << ln);
      c = i_pm.evt_cnt[ln];
      step(pin, 1, r[18:0]);
      `CHK(irq, r[18:0])
      step(pin, 0, f[18:0]);
      `CHK(wake, |f)
      `CHK(i_pm.evt_cnt[ln] - c, (m == 2) ? 2 : 1)
      apb(1, OFF_PEND, 0);
      rdchk(OFF_PEND, f);
      apb(1, OFF_PEND, 32'h1 << ln);
      rdchk(OFF_PEND, 0);
      apb(1, OFF_IRQ_MASK, 0);
      apb(1, OFF_EVT_MASK, 0);
      apb(1, OFF_RISE_EN, 32'h1 << ln);
      i_pm.pulse(pin, 5);
      repeat (6) @(posedge clk);
      rdchk(OFF_PEND, 32'h1 << ln);
      `CHK(irq, 19'h0)
    end
    $display("edge test done");
    apb(1, OFF_RISE_EN, 32'h70000);
    apb(1, OFF_FALL_EN, 32'h70000);
    step(112, 1, 0);
    step(112, 0, 0);
    apb(1, OFF_CTRL, 1);
    step(112, 1, 19'h10000);
    step(112, 0, 19'h10000);
    step(113, 1, 19'h20000);
    step(114, 1, 19'h40000);
    // Byte strobes: an unstrobed byte neither clears pending nor moves a mask
    stb <= 4'h3;
    apb(1, OFF_PEND, 32'h7ffff);
    rdchk(OFF_PEND, 32'h40000);
    stb <= 4'h4;
    apb(1, OFF_IRQ_MASK, 32'hffffffff);
    `CHK(irq, 19'h40000)
    apb(1, OFF_PEND, 32'h40000);
    stb <= 4'hf;
    rdchk(OFF_PEND, 0);
    `CHK(irq, 19'h00000)
    $display("internal line test done");
    summarize();
  end
endmodule
